// *** inc/pcd_pkg.sv ***
// Constants, register map and carrier types of the pattern compare and delta engine.
package pcd_pkg;
   localparam logic [7:0] OP_CMP_PATTERN = 8'h06;
   localparam logic [7:0] OP_DELTA = 8'h07;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_OPFLAGS = 4'h1;
   localparam logic [3:0] REG_XFER = 4'h2;
   localparam logic [3:0] REG_EXPECT = 4'h3;
   localparam logic [3:0] REG_CPL_LO = 4'h4;
   localparam logic [3:0] REG_CPL_HI = 4'h5;
   localparam logic [3:0] REG_SRC1_LO = 4'h6;
   localparam logic [3:0] REG_SRC1_HI = 4'h7;
   localparam logic [3:0] REG_SRC2_LO = 4'h8;
   localparam logic [3:0] REG_SRC2_HI = 4'h9;
   localparam logic [3:0] REG_DREC_LO = 4'hA;
   localparam logic [3:0] REG_DREC_HI = 4'hB;
   localparam logic [3:0] REG_DMAX = 4'hC;
   localparam logic [3:0] REG_RESULT = 4'hD;
   localparam logic [3:0] REG_BYTES = 4'hE;
   localparam logic [3:0] REG_DSIZE = 4'hF;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_BUSY_BIT = 0;
   localparam int CTRL_DONE_BIT = 1;
   localparam int FLAG_CHECK_BIT = 8;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [7:0] ST_NONE = 8'h00;
   localparam logic [7:0] ST_SUCCESS = 8'h01;
   localparam logic [7:0] ST_FALSE_PRED = 8'h02;
   localparam logic [7:0] ST_PAGE_FAULT = 8'h03;
   localparam logic [7:0] ST_BAD_OPCODE = 8'h10;
   localparam logic [7:0] ST_OVERLAP = 8'h11;
   localparam logic [7:0] ST_BAD_SIZE = 8'h12;
   localparam logic [31:0] PATTERN_STEP = 32'h0000_0001;
   localparam logic [31:0] BLOCK_BYTES = 32'h0000_0008;
   localparam logic [31:0] ENTRY_BYTES = 32'h0000_000A;
   localparam logic [31:0] DELTA_MAX_XFER = 32'h0008_0000;
   localparam logic [3:0] ENTRY_LAST_IDX = 4'h9;
   localparam logic [3:0] CPL_LAST_IDX = 4'h2;
   typedef struct packed {
      logic req;
      logic we;
      logic [63:0] addr;
      logic [63:0] wdata;
      logic [7:0] be;
   } pcd_mem_req_t;
   typedef struct packed {
      logic ack;
      logic fault;
      logic [63:0] rdata;
   } pcd_mem_rsp_t;
   typedef enum logic [2:0] {S_IDLE, S_CHECK, S_RDA, S_RDB, S_WRD, S_NXT,
      S_CPL} pcd_state_t;
endpackage

// *** hdl/pcd_engine.sv ***
// Pattern compare and delta record engine with an Avalon-MM register slave.
`timescale 1ns/1ns
`default_nettype none
module pcd_engine
   import pcd_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output var pcd_mem_req_t memReq,
   input wire pcd_mem_rsp_t memRsp
);

   // ----------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------
   function automatic logic [7:0] byteOf(input logic [63:0] w,
      input logic [2:0] i);
      byteOf = w[8*i +: 8];
   endfunction

   function automatic logic overlaps(input logic [63:0] a,
      input logic [31:0] alen, input logic [63:0] b, input logic [31:0] blen);
      overlaps = (alen != 32'h0) && (blen != 32'h0) &&
         (a < b + {32'h0, blen}) && (b < a + {32'h0, alen});
   endfunction

   function automatic logic [7:0] predStatus(input logic [7:0] op,
      input logic chk, input logic [7:0] expv, input logic [1:0] res);
      predStatus = ST_SUCCESS;
      if (chk)
      begin
         if (op == OP_CMP_PATTERN)
         begin
            if (res[0] != expv[0])
               predStatus = ST_FALSE_PRED;
         end
         else if (!expv[res])
            predStatus = ST_FALSE_PRED;
      end
   endfunction

   // ----------------------------------------------------------------
   // Register slave.
   // ----------------------------------------------------------------
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [31:0] cfg_reg [1:12];
   logic [31:0] cfg_next [1:12];
   logic startPulse, clrDone;
   logic [31:0] readVal;
   pcd_state_t state_reg, state_next;
   logic busy_reg, busy_next, done_reg, done_next;
   logic [31:0] pos_reg, pos_next, used_reg, used_next;
   logic [31:0] bytesDone_reg, bytesDone_next;
   logic [63:0] dataA_reg, dataA_next, dataB_reg, dataB_next;
   logic [63:0] faultAddr_reg, faultAddr_next;
   logic [1:0] result_reg, result_next, endRes;
   logic [7:0] status_reg, status_next;
   logic [3:0] wIdx_reg, wIdx_next;
   pcd_mem_req_t mreq_reg, mreq_next;

   always_comb
   begin
      case (address[5:2])
         REG_CTRL: readVal = {30'h0, done_reg, busy_reg};
         REG_RESULT: readVal = {22'h0, result_reg, status_reg};
         REG_BYTES: readVal = bytesDone_reg;
         REG_DSIZE: readVal = used_reg;
         default: readVal = cfg_reg[address[5:2]];
      endcase
   end

   always_comb
   begin
      ack_next = (read | write) & ~ack_reg;
      rdata_next = rdata_reg;
      cfg_next = cfg_reg;
      startPulse = 1'b0;
      clrDone = 1'b0;
      if (read & ~ack_reg)
         rdata_next = readVal;
      if (write & ack_reg)
      begin
         if (address[5:2] == REG_CTRL)
         begin
            startPulse = byteenable[0] & writedata[CTRL_START_BIT];
            clrDone = byteenable[0] & writedata[CTRL_DONE_BIT];
         end
         else if (address[5:2] <= REG_DMAX && !busy_reg)
         begin
            for (int b = 0; b < 4; b++)
               if (byteenable[b])
                  cfg_next[address[5:2]][8*b +: 8] = writedata[8*b +: 8];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ack_reg <= 1'b0;
         rdata_reg <= CFG_RESET;
         for (int i = 1; i <= 12; i++)
            cfg_reg[i] <= CFG_RESET;
      end
      else
      begin
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         cfg_reg <= cfg_next;
      end
   end

   assign waitrequest = (read | write) & ~ack_reg;
   assign readdata = rdata_reg;

   // ----------------------------------------------------------------
   // Descriptor fields and addresses.
   // ----------------------------------------------------------------
   logic [7:0] opCode, expRes, entryByte;
   logic checkRes, ackNow;
   logic [31:0] xfer, maxD;
   logic [63:0] cplAddr, src1, src2, drec, srcAddr, wrAddr, cplWord;

   assign opCode = cfg_reg[REG_OPFLAGS][7:0];
   assign checkRes = cfg_reg[REG_OPFLAGS][FLAG_CHECK_BIT];
   assign xfer = cfg_reg[REG_XFER];
   assign expRes = cfg_reg[REG_EXPECT][7:0];
   assign maxD = cfg_reg[REG_DMAX];
   assign cplAddr = {cfg_reg[REG_CPL_HI], cfg_reg[REG_CPL_LO]};
   assign src1 = {cfg_reg[REG_SRC1_HI], cfg_reg[REG_SRC1_LO]};
   assign src2 = {cfg_reg[REG_SRC2_HI], cfg_reg[REG_SRC2_LO]};
   assign drec = {cfg_reg[REG_DREC_HI], cfg_reg[REG_DREC_LO]};
   assign srcAddr = ((state_reg == S_RDB) ? src2 : src1) + {32'h0, pos_reg};
   assign wrAddr = drec + {32'h0, used_reg} + {60'h0, wIdx_reg};
   assign ackNow = mreq_reg.req & memRsp.ack;
   assign endRes = (used_reg != 32'h0) ? 2'h1 : 2'h0;

   always_comb
   begin
      if (wIdx_reg == 4'h0)
         entryByte = pos_reg[10:3];
      else if (wIdx_reg == 4'h1)
         entryByte = pos_reg[18:11];
      else
         entryByte = byteOf(dataB_reg, 3'(wIdx_reg - 4'h2));
      if (wIdx_reg == 4'h0)
         cplWord = {bytesDone_reg, 16'h0, 6'h0, result_reg, status_reg};
      else if (wIdx_reg == 4'h1)
         cplWord = faultAddr_reg;
      else
         cplWord = {32'h0, used_reg};
   end

   // ----------------------------------------------------------------
   // Operation sequencer.
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      busy_next = busy_reg;
      done_next = done_reg & ~clrDone;
      pos_next = pos_reg;
      used_next = used_reg;
      bytesDone_next = bytesDone_reg;
      dataA_next = dataA_reg;
      dataB_next = dataB_reg;
      faultAddr_next = faultAddr_reg;
      result_next = result_reg;
      status_next = status_reg;
      wIdx_next = wIdx_reg;
      mreq_next = '0;
      if (ackNow && memRsp.fault && state_reg != S_CPL)
      begin
         faultAddr_next = mreq_reg.addr;
         status_next = ST_PAGE_FAULT;
         result_next = endRes;
         bytesDone_next = pos_reg;
         state_next = S_CPL;
      end
      else
      begin
         case (state_reg)
            S_IDLE:
               if (startPulse)
               begin
                  busy_next = 1'b1;
                  state_next = S_CHECK;
               end
            S_CHECK:
            begin
               pos_next = 32'h0;
               used_next = 32'h0;
               result_next = 2'h0;
               bytesDone_next = 32'h0;
               faultAddr_next = 64'h0;
               status_next = ST_NONE;
               state_next = S_RDA;
               if (opCode == OP_CMP_PATTERN)
               begin
                  if (xfer == 32'h0)
                  begin
                     status_next = predStatus(opCode, checkRes, expRes, 2'h0);
                     state_next = S_CPL;
                  end
               end
               else if (opCode == OP_DELTA)
               begin
                  if (overlaps(drec, maxD, src1, xfer) ||
                     overlaps(drec, maxD, src2, xfer))
                  begin
                     status_next = ST_OVERLAP;
                     state_next = S_CPL;
                  end
                  else if (xfer > DELTA_MAX_XFER)
                  begin
                     status_next = ST_BAD_SIZE;
                     state_next = S_CPL;
                  end
                  else if (xfer == 32'h0)
                  begin
                     status_next = predStatus(opCode, checkRes, expRes, 2'h0);
                     state_next = S_CPL;
                  end
               end
               else
               begin
                  status_next = ST_BAD_OPCODE;
                  state_next = S_CPL;
               end
            end
            S_RDA:
               if (!ackNow)
               begin
                  mreq_next.req = 1'b1;
                  mreq_next.addr = {srcAddr[63:3], 3'h0};
                  mreq_next.be = 8'hFF;
               end
               else if (opCode == OP_DELTA)
               begin
                  dataA_next = memRsp.rdata;
                  state_next = S_RDB;
               end
               else if (byteOf(memRsp.rdata, srcAddr[2:0]) !=
                  byteOf(src2, pos_reg[2:0]))
               begin
                  result_next = 2'h1;
                  bytesDone_next = pos_reg;
                  status_next = predStatus(opCode, checkRes, expRes, 2'h1);
                  state_next = S_CPL;
               end
               else
               begin
                  pos_next = pos_reg + PATTERN_STEP;
                  if (pos_reg + PATTERN_STEP == xfer)
                  begin
                     result_next = 2'h0;
                     status_next = predStatus(opCode, checkRes, expRes, 2'h0);
                     state_next = S_CPL;
                  end
               end
            S_RDB:
               if (!ackNow)
               begin
                  mreq_next.req = 1'b1;
                  mreq_next.addr = {srcAddr[63:3], 3'h0};
                  mreq_next.be = 8'hFF;
               end
               else
               begin
                  dataB_next = memRsp.rdata;
                  if (memRsp.rdata == dataA_reg)
                     state_next = S_NXT;
                  else if (used_reg + ENTRY_BYTES > maxD)
                  begin
                     result_next = 2'h2;
                     bytesDone_next = pos_reg;
                     status_next = predStatus(opCode, checkRes, expRes, 2'h2);
                     state_next = S_CPL;
                  end
                  else
                  begin
                     wIdx_next = 4'h0;
                     state_next = S_WRD;
                  end
               end
            S_WRD:
               if (!ackNow)
               begin
                  mreq_next.req = 1'b1;
                  mreq_next.we = 1'b1;
                  mreq_next.addr = {wrAddr[63:3], 3'h0};
                  mreq_next.be = 8'h01 << wrAddr[2:0];
                  mreq_next.wdata = {56'h0, entryByte} << {wrAddr[2:0], 3'h0};
               end
               else if (wIdx_reg == ENTRY_LAST_IDX)
               begin
                  used_next = used_reg + ENTRY_BYTES;
                  state_next = S_NXT;
               end
               else
                  wIdx_next = wIdx_reg + 4'h1;
            S_NXT:
               if (pos_reg + BLOCK_BYTES >= xfer)
               begin
                  result_next = endRes;
                  bytesDone_next = 32'h0;
                  status_next = predStatus(opCode, checkRes, expRes, endRes);
                  state_next = S_CPL;
               end
               else
               begin
                  pos_next = pos_reg + BLOCK_BYTES;
                  state_next = S_RDA;
               end
            S_CPL:
               if (!ackNow)
               begin
                  mreq_next.req = 1'b1;
                  mreq_next.we = 1'b1;
                  mreq_next.addr = cplAddr + {59'h0, wIdx_reg[1:0], 3'h0};
                  mreq_next.be = 8'hFF;
                  mreq_next.wdata = cplWord;
               end
               else if (wIdx_reg == CPL_LAST_IDX)
               begin
                  busy_next = 1'b0;
                  done_next = 1'b1;
                  state_next = S_IDLE;
               end
               else
                  wIdx_next = wIdx_reg + 4'h1;
            default:
               state_next = S_IDLE;
         endcase
      end
      if (state_next == S_CPL && state_reg != S_CPL)
         wIdx_next = 4'h0;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_reg <= S_IDLE;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         pos_reg <= 32'h0;
         used_reg <= 32'h0;
         bytesDone_reg <= 32'h0;
         dataA_reg <= 64'h0;
         dataB_reg <= 64'h0;
         faultAddr_reg <= 64'h0;
         result_reg <= 2'h0;
         status_reg <= ST_NONE;
         wIdx_reg <= 4'h0;
         mreq_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         pos_reg <= pos_next;
         used_reg <= used_next;
         bytesDone_reg <= bytesDone_next;
         dataA_reg <= dataA_next;
         dataB_reg <= dataB_next;
         faultAddr_reg <= faultAddr_next;
         result_reg <= result_next;
         status_reg <= status_next;
         wIdx_reg <= wIdx_next;
         mreq_reg <= mreq_next;
      end
   end

   assign memReq = mreq_reg;

endmodule
`default_nettype wire

// *** sim/pcd_engine_sva.sv ***
// Port checker of the pattern compare and delta engine.
`timescale 1ns/1ns
`default_nettype none
module pcd_engine_sva
   import pcd_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire pcd_mem_req_t memReq,
   input wire pcd_mem_rsp_t memRsp
);
   // --------------------
   // Helper state
   // --------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   logic [1:0] cplCnt_reg, cplCnt_next;
   logic [63:0] cplBase_reg, cplBase_next, lastByte_reg, lastByte_next;
   logic fullWr, oneWr;
   assign fullWr = memReq.req && memReq.we && memReq.be == 8'hFF;
   assign oneWr = memReq.req && memReq.we && memReq.be != 8'hFF;
   always_comb
   begin
      cplCnt_next = cplCnt_reg;
      cplBase_next = cplBase_reg;
      lastByte_next = lastByte_reg;
      if (fullWr && memRsp.ack)
      begin
         cplCnt_next = cplCnt_reg == 2'h2 ? 2'h0 : cplCnt_reg + 2'h1;
         if (cplCnt_reg == 2'h0)
            cplBase_next = memReq.addr;
         lastByte_next = 64'h0;
      end
      if (oneWr && memRsp.ack)
         lastByte_next = memReq.addr + $clog2(memReq.be);
   end
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cplCnt_reg <= 2'h0;
         cplBase_reg <= 64'h0;
         lastByte_reg <= 64'h0;
      end
      else
      begin
         cplCnt_reg <= cplCnt_next;
         cplBase_reg <= cplBase_next;
         lastByte_reg <= lastByte_next;
      end
   end
   wait_state_a: assert property ($rose(read || write) |-> waitrequest
      ##1 !waitrequest) else $error("no single wait state");
   req_hold_a: assert property (memReq.req && !memRsp.ack |=>
      $stable(memReq)) else $error("memory request changed early");
   req_drop_a: assert property (memReq.req && memRsp.ack |=> !memReq.req)
      else $error("memory request not dropped");
   addr_align_a: assert property (memReq.req |-> memReq.addr[2:0] == 3'h0)
      else $error("unaligned memory address");
   entry_lane_a: assert property (oneWr |-> $onehot(memReq.be))
      else $error("entry write not one byte");
   entry_order_a: assert property (oneWr && memRsp.ack |->
      lastByte_reg == 64'h0 || memReq.addr + $clog2(memReq.be) ==
      lastByte_reg + 64'h1) else $error("entry bytes out of order");
   cpl_last_a: assert property (memReq.req && !fullWr |->
      cplCnt_reg == 2'h0) else $error("access after completion start");
   cpl_order_a: assert property (fullWr && cplCnt_reg != 2'h0 |->
      memReq.addr == cplBase_reg + {cplCnt_reg, 3'h0})
      else $error("completion qword misplaced");
   result_code_a: assert property (read && !waitrequest &&
      address[5:2] == REG_RESULT |-> readdata[9:8] != 2'h3)
      else $error("illegal result code");
   cover property (oneWr && memRsp.ack);
   cover property (memReq.req && memRsp.ack && memRsp.fault);
   cover property (fullWr && cplCnt_reg == 2'h2 && memRsp.ack);
endmodule
bind pcd_engine pcd_engine_sva chk (.clock(clock), .rst(rst),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .memReq(memReq), .memRsp(memRsp));
`default_nettype wire

// *** sim/pcd_mem_model.sv ***
// System memory model with random latency and one faulting qword.
`timescale 1ns/1ns
`default_nettype none
module pcd_mem_model
   import pcd_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire pcd_mem_req_t memReq,
   output var pcd_mem_rsp_t memRsp,
   input wire logic [63:0] faultAt
);
   // --------------------
   // Memory
   // --------------------
   logic [7:0] mem [logic [63:0]];
   int waitCnt;
   function automatic logic [7:0] rd(input logic [63:0] a);
      return mem.exists(a) ? mem[a] : 8'h00;
   endfunction
   always @(posedge clock)
   begin
      memRsp.ack <= 1'b0;
      memRsp.fault <= 1'b0;
      memRsp.rdata <= ~memRsp.rdata;
      if (rst)
      begin
         memRsp.rdata <= 64'h0;
         waitCnt <= 0;
      end
      else if (memReq.req && !memRsp.ack)
      begin
         if (waitCnt != 0)
            waitCnt <= waitCnt - 1;
         else
         begin
            waitCnt <= $urandom_range(3);
            memRsp.ack <= 1'b1;
            memRsp.fault <= memReq.addr == faultAt;
            for (int i = 0; i < 8; i++)
            begin
               if (!memReq.we)
                  memRsp.rdata[8*i +: 8] <= rd(memReq.addr + i);
               else if (memReq.be[i] && memReq.addr != faultAt)
                  mem[memReq.addr + i] = memReq.wdata[8*i +: 8];
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/pcd_engine_tb_top.sv ***
// Random and corner case testbench of the pattern compare and delta engine.
`timescale 1ns/1ns
`default_nettype none
module pcd_engine_tb_top
   import pcd_pkg::*;
();
   // --------------------
   // Bench
   // --------------------
   localparam logic [31:0] S1 = 32'h0000_1000;
   localparam logic [31:0] S2 = 32'h0000_2000;
   localparam logic [31:0] CPL = 32'h0000_4000;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [5:0] address = 6'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, q, len, maxd, drec, lastRes;
   logic waitrequest, chk;
   logic [7:0] op, expv;
   logic [63:0] pat, faultAt;
   logic [7:0] s1 [0:87];
   logic [7:0] s2 [0:87];
   pcd_mem_req_t memReq;
   pcd_mem_rsp_t memRsp;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   int tnum, n;
   pcd_engine uut (.clock(clock), .rst(rst), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
      .memReq(memReq), .memRsp(memRsp));
   pcd_mem_model mdl (.clock(clock), .rst(rst), .memReq(memReq),
      .memRsp(memRsp), .faultAt(faultAt));
   always #50 clock = ~clock;
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t reg %h exp %h", $time, got, exp);
      end
   endtask
   task automatic checkMem(input logic [63:0] a, input logic [7:0] exp);
      checked++;
      if (mdl.rd(a) !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t mem %h exp %h", $time, a, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] idx,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clock);
      read <= ~wr;
      write <= wr;
      address <= {idx, 2'b00};
      writedata <= d;
      do
         @(posedge clock);
      while (waitrequest !== 1'b0);
      r = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic runOp();
      logic [31:0] v [1:12];
      logic [31:0] eBytes, used;
      logic [63:0] eFault;
      logic [7:0] eSt;
      logic [1:0] eRes;
      logic d, srcF, ovf, recF;
      int b, j;
      int offs[$];
      v = '{{23'h0, chk, op}, len, {24'h0, expv}, CPL, 32'h0, S1, 32'h0,
         op == OP_DELTA ? S2 : pat[31:0], op == OP_DELTA ? 32'h0 : pat[63:32],
         drec, 32'h0, maxd};
      for (j = 0; j < 24; j++)
         mdl.mem[CPL + j] = 8'hEE;
      for (j = 0; j < 88; j++)
      begin
         mdl.mem[S1 + j] = s1[j];
         mdl.mem[S2 + j] = s2[j];
      end
      for (j = 1; j <= 12; j++)
         bus(1'b1, j[3:0], v[j], q);
      eSt = ST_SUCCESS;
      eRes = 2'h0;
      eBytes = 32'h0;
      used = 32'h0;
      if (op != OP_DELTA && op != OP_CMP_PATTERN)
         eSt = ST_BAD_OPCODE;
      else if (op == OP_DELTA && len > DELTA_MAX_XFER)
         eSt = ST_BAD_SIZE;
      else if (op == OP_DELTA && ((drec < S1 + len && drec + maxd > S1) ||
         (drec < S2 + len && drec + maxd > S2)))
         eSt = ST_OVERLAP;
      else if (op == OP_CMP_PATTERN)
      begin
         for (j = 0; j < len; j++)
            if (S1 + (j & ~7) == faultAt || s1[j] !== pat[8*(j%8) +: 8])
            begin
               eRes = S1 + (j & ~7) == faultAt ? 2'h0 : 2'h1;
               eSt = eRes != 2'h0 ? ST_SUCCESS : ST_PAGE_FAULT;
               eBytes = j;
               break;
            end
      end
      else
      begin
         for (b = 0; b < len; b += 8)
         begin
            d = 1'b0;
            for (j = 0; j < 8; j++)
               d |= s1[b + j] !== s2[b + j];
            srcF = S1 + b == faultAt || S2 + b == faultAt;
            ovf = !srcF && d && used + 10 > maxd;
            recF = !srcF && !ovf && d && (((drec + used) & ~32'h7) ==
               faultAt || ((drec + used + 9) & ~32'h7) == faultAt);
            if (srcF || ovf || recF)
            begin
               eSt = ovf ? ST_SUCCESS : ST_PAGE_FAULT;
               eRes = ovf ? 2'h2 : 2'h0;
               eBytes = b;
               break;
            end
            if (d)
               offs.push_back(b / 8);
            used += d ? 10 : 0;
         end
         if (eRes != 2'h2)
            eRes = used != 0;
      end
      if (eSt == ST_SUCCESS && chk)
         eSt = (op == OP_CMP_PATTERN ? eRes[0] == expv[0] : expv[eRes])
            ? ST_SUCCESS : ST_FALSE_PRED;
      lastRes = {22'h0, eRes, eSt};
      bus(1'b1, REG_CTRL, 32'h1, q);
      do
         bus(1'b0, REG_CTRL, 32'h0, q);
      while (q[CTRL_DONE_BIT] !== 1'b1);
      bus(1'b1, REG_CTRL, 32'h2, q);
      bus(1'b0, REG_RESULT, 32'h0, q);
      check32(q, lastRes);
      bus(1'b0, REG_BYTES, 32'h0, q);
      check32(q, eBytes);
      bus(1'b0, REG_DSIZE, 32'h0, q);
      check32(q, used);
      checkMem(CPL, eSt);
      checkMem(CPL + 1, {6'h0, eRes});
      for (j = 0; j < 4; j++)
      begin
         checkMem(CPL + 4 + j, eBytes[8*j +: 8]);
         checkMem(CPL + 16 + j, used[8*j +: 8]);
      end
      eFault = eSt == ST_PAGE_FAULT ? faultAt : 64'h0;
      for (j = 0; j < 8; j++)
         checkMem(CPL + 8 + j, eFault[8*j +: 8]);
      foreach (offs[k])
      begin
         checkMem(drec + 10 * k, offs[k][7:0]);
         checkMem(drec + 10 * k + 1, offs[k][15:8]);
         for (j = 0; j < 8; j++)
            checkMem(drec + 10 * k + 2 + j, s2[8 * offs[k] + j]);
      end
      $display("test %0d op %h done", tnum, op);
   endtask
   initial
   begin
      faultAt = 64'hFFFF_0000;
      void'($urandom(5550));
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      bus(1'b0, REG_RESULT, 32'h0, q);
      check32(q, CFG_RESET);
      for (tnum = 0; tnum < 32; tnum++)
      begin
         op = tnum[0] || tnum >= 30 ? OP_DELTA : OP_CMP_PATTERN;
         if (tnum == 28)
            op = 8'hFF;
         pat = {$urandom, $urandom};
         len = op == OP_DELTA ? 8 * $urandom_range(10) : $urandom_range(40);
         maxd = $urandom_range(1) ? 32'd80 : 32'd100;
         chk = 1'($urandom);
         expv = 8'($urandom);
         drec = 32'h0000_3000;
         n = $urandom_range(4);
         faultAt = n == 1 ? S1 : n == 2 ? S2 : n == 3 ? drec : 64'hFFFF_0000;
         faultAt = faultAt + 8 * $urandom_range(5);
         for (n = 0; n < 88; n++)
         begin
            s1[n] = op == OP_DELTA ? 8'($urandom) : pat[8*(n%8) +: 8];
            s2[n] = s1[n] ^ ((n % 8 == 0 && $urandom_range(1)) ? 8'hFF : 8'h0);
         end
         if ($urandom_range(1))
            s1[$urandom_range(len)] ^= 8'h10;
         if (tnum >= 30)
         begin
            faultAt = 64'hFFFF_0000;
            len = tnum == 30 ? 32'd64 : 32'h0008_0008;
            drec = tnum == 30 ? S2 + 16 : 32'h0009_0000;
         end
         runOp();
      end
      bus(1'b1, REG_RESULT, 32'h0000_0155, q);
      bus(1'b0, REG_RESULT, 32'h0, q);
      check32(q, lastRes);
      tally_and_finish();
   end
endmodule
`default_nettype wire
